/* File: design/hpsl_device.sv */
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
module hpsl_device
  import hpsl_pkg::*;
#(
  parameter int PINS = 16
) (
  input wire logic clk,
  input wire logic resetn,
  hpsl_if.device hp,
  input wire logic soft_reset,
  input wire logic dsp_ctrl_we,
  input wire logic dsp_pcr_we,
  input wire logic dsp_ddr_we,
  input wire logic dsp_gdr_we,
  input wire logic [23:0] dsp_wdata,
  input wire logic dsp_tx_load,
  input wire logic [23:0] dsp_tx_data,
  input wire logic dsp_rx_take,
  input wire logic dsp_cmd_ack,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  output logic [PINS-1:0] gpio_read,
  output logic [23:0] dsp_rx_data,
  output logic dsp_rx_full,
  output logic dsp_tx_empty,
  output logic dsp_cmd_pending,
  output logic [6:0] dsp_cmd_vector,
  output logic dsp_rx_irq,
  output logic dsp_tx_irq,
  output logic dsp_cmd_irq,
  output logic addr_line8_active,
  output logic addr_line9_active
);

  // ==========================================================================
  // DSP-side control registers.
  logic rst;
  logic [23:0] dsp_control_register_reg;
  logic [23:0] port_control_register_reg;
  logic [PINS-1:0] gpio_direction_register_reg;
  logic [PINS-1:0] gpio_data_register_reg;

  assign rst = ~resetn | soft_reset;

  always_ff @(posedge clk) begin
    if (rst) begin
      dsp_control_register_reg <= CTRL_RESET;
      port_control_register_reg <= CTRL_RESET;
      gpio_direction_register_reg <= '0;
      gpio_data_register_reg <= '0;
    end else begin
      if (dsp_ctrl_we) begin
        dsp_control_register_reg <= dsp_wdata;
      end
      if (dsp_pcr_we) begin
        port_control_register_reg <= dsp_wdata;
      end
      if (dsp_ddr_we) begin
        gpio_direction_register_reg <= dsp_wdata[PINS-1:0];
      end
      if (dsp_gdr_we) begin
        gpio_data_register_reg <= dsp_wdata[PINS-1:0];
      end
    end
  end

  // ==========================================================================
  // Mode selection and GPIO.
  wire gpio_mode = ~|port_control_register_reg[PCR_MODE_HI:PCR_MODE_LO];
  wire port_enable_bit = port_control_register_reg[PCR_PORT_EN];
  wire multiplexed_bus_mode = port_control_register_reg[PCR_MUX_BUS];
  wire addr8_next = port_enable_bit & (~multiplexed_bus_mode | port_control_register_reg[PCR_ADDR8_EN]);
  wire addr9_next = port_enable_bit & (~multiplexed_bus_mode | port_control_register_reg[PCR_ADDR9_EN]);
  // Outside GPIO mode the pins belong to the host port, so GPIO drive is withdrawn.
  wire [PINS-1:0] pin_oe_next = gpio_mode ? gpio_direction_register_reg : '0;
  wire [PINS-1:0] gpio_read_next = (gpio_data_register_reg & gpio_direction_register_reg)
                                 | (pin_in & ~gpio_direction_register_reg);

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_oe <= '0;
      pin_out <= '0;
      gpio_read <= '0;
      addr_line8_active <= 1'b0;
      addr_line9_active <= 1'b0;
    end else begin
      pin_oe <= pin_oe_next;
      pin_out <= gpio_data_register_reg;
      gpio_read <= gpio_read_next;
      addr_line8_active <= addr8_next;
      addr_line9_active <= addr9_next;
    end
  end

  // ==========================================================================
  // Host register decode. Strobes are honoured only while the port is enabled.
  logic [7:0] icr_reg;
  logic [7:0] ivr_reg;
  logic cmd_pending_reg;
  logic [6:0] cmd_vector_reg;
  logic [23:0] tx_bytes_reg;
  logic [23:0] rx_bytes_reg;
  logic transmit_empty_flag_reg;
  logic receive_full_flag_reg;
  logic dsp_rx_full_reg;

  wire host_wr = hp.host_strobe & ~hp.host_read & port_enable_bit;
  wire host_rd = hp.host_strobe & hp.host_read & port_enable_bit;
  wire wr_icr = host_wr & (hp.ha == HA_ICR);
  wire wr_cvr = host_wr & (hp.ha == HA_CVR);
  wire wr_ivr = host_wr & (hp.ha == HA_IVR);
  // Writes to transmit bytes while the word is still pending are ignored.
  wire wr_tx_ok = host_wr & transmit_empty_flag_reg;
  wire wr_tx_high = wr_tx_ok & (hp.ha == HA_BYTE_HIGH);
  wire wr_tx_mid = wr_tx_ok & (hp.ha == HA_BYTE_MID);
  wire wr_tx_low = wr_tx_ok & (hp.ha == HA_BYTE_LOW);
  wire rd_rx_low = host_rd & (hp.ha == HA_BYTE_LOW) & receive_full_flag_reg;

  // ==========================================================================
  // Data flags.
  wire tx_move = ~transmit_empty_flag_reg & ~dsp_rx_full_reg;
  wire rx_load = dsp_tx_load & ~receive_full_flag_reg;
  wire transmit_empty_flag_next = tx_move ? 1'b1 : (wr_tx_low ? 1'b0 : transmit_empty_flag_reg);
  wire receive_full_flag_next = rx_load ? 1'b1 : (rd_rx_low ? 1'b0 : receive_full_flag_reg);
  // A move and a take can fall in one cycle only while the DSP flag is clear, as a move needs it clear; then the move wins.
  wire hrdf_next = tx_move ? 1'b1 : (dsp_rx_take ? 1'b0 : dsp_rx_full_reg);
  wire transmit_ready_flag = transmit_empty_flag_reg & ~dsp_rx_full_reg;
  // The host's own write wins over the core's acceptance in the same cycle.
  wire hc_next = wr_cvr ? hp.hd_host[CVR_CMD_BIT] : (dsp_cmd_ack ? 1'b0 : cmd_pending_reg);

  always_ff @(posedge clk) begin
    if (rst) begin
      transmit_empty_flag_reg <= 1'b1;
      receive_full_flag_reg <= 1'b0;
      dsp_rx_full_reg <= 1'b0;
      cmd_pending_reg <= 1'b0;
      cmd_vector_reg <= CVR_VECTOR_RESET;
      icr_reg <= 8'h00;
      ivr_reg <= IVR_RESET;
    end else begin
      transmit_empty_flag_reg <= transmit_empty_flag_next;
      receive_full_flag_reg <= receive_full_flag_next;
      dsp_rx_full_reg <= hrdf_next;
      cmd_pending_reg <= hc_next;
      if (wr_cvr) begin
        cmd_vector_reg <= hp.hd_host[6:0];
      end
      if (wr_icr) begin
        icr_reg <= hp.hd_host;
      end
      if (wr_ivr) begin
        ivr_reg <= hp.hd_host;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_bytes_reg <= 24'h00_0000;
      rx_bytes_reg <= 24'h00_0000;
      dsp_rx_data <= 24'h00_0000;
    end else begin
      if (wr_tx_high) begin
        tx_bytes_reg[23:16] <= hp.hd_host;
      end
      if (wr_tx_mid) begin
        tx_bytes_reg[15:8] <= hp.hd_host;
      end
      if (wr_tx_low) begin
        tx_bytes_reg[7:0] <= hp.hd_host;
      end
      if (rx_load) begin
        rx_bytes_reg <= dsp_tx_data;
      end
      if (tx_move) begin
        dsp_rx_data <= tx_bytes_reg;
      end
    end
  end

  // ==========================================================================
  // Host requests, taken from next-state flags so they track the flags exactly.
  wire xreq_next = port_enable_bit & icr_reg[ICR_XMIT_REQ_EN] & transmit_empty_flag_next;
  wire receive_request_enable_next = port_enable_bit & icr_reg[ICR_RECV_REQ_EN] & receive_full_flag_next;

  always_ff @(posedge clk) begin
    if (rst) begin
      hp.transmit_request_out <= 1'b0;
      hp.receive_request_out <= 1'b0;
      hp.host_request_out <= 1'b0;
    end else begin
      hp.transmit_request_out <= xreq_next;
      hp.receive_request_out <= receive_request_enable_next;
      hp.host_request_out <= xreq_next | receive_request_enable_next;
    end
  end

  // ==========================================================================
  // Host read data and interrupt vector.
  wire any_request = hp.transmit_request_out | hp.receive_request_out;
  wire vec_drive = any_request & hp.host_acknowledge_in & port_enable_bit;
  wire [7:0] isr_value = {hp.host_request_out, 2'b00, dsp_control_register_reg[HCR_FLAG_THREE],
                          dsp_control_register_reg[HCR_FLAG_TWO], transmit_ready_flag,
                          transmit_empty_flag_reg, receive_full_flag_reg};
  wire [7:0] rd_value = (hp.ha == HA_ICR) ? icr_reg :
                        (hp.ha == HA_CVR) ? {cmd_pending_reg, cmd_vector_reg} :
                        (hp.ha == HA_ISR) ? isr_value :
                        (hp.ha == HA_IVR) ? ivr_reg :
                        (hp.ha == HA_BYTE_HIGH) ? rx_bytes_reg[23:16] :
                        (hp.ha == HA_BYTE_MID) ? rx_bytes_reg[15:8] :
                        (hp.ha == HA_BYTE_LOW) ? rx_bytes_reg[7:0] : 8'h00;

  always_ff @(posedge clk) begin
    if (rst) begin
      hp.hd_dev <= 8'h00;
      hp.hd_dev_oe <= 1'b0;
    end else begin
      hp.hd_dev <= vec_drive ? ivr_reg : (host_rd ? rd_value : 8'h00);
      hp.hd_dev_oe <= vec_drive | host_rd;
    end
  end

  // ==========================================================================
  // DSP-side status and interrupts.
  always_ff @(posedge clk) begin
    if (rst) begin
      dsp_rx_full <= 1'b0;
      dsp_tx_empty <= 1'b1;
      dsp_cmd_pending <= 1'b0;
      dsp_cmd_vector <= CVR_VECTOR_RESET;
      dsp_rx_irq <= 1'b0;
      dsp_tx_irq <= 1'b0;
      dsp_cmd_irq <= 1'b0;
    end else begin
      dsp_rx_full <= hrdf_next;
      dsp_tx_empty <= ~receive_full_flag_next;
      dsp_cmd_pending <= hc_next;
      dsp_cmd_vector <= wr_cvr ? hp.hd_host[6:0] : cmd_vector_reg;
      dsp_rx_irq <= dsp_control_register_reg[HCR_RX_IRQ_EN] & hrdf_next;
      dsp_tx_irq <= dsp_control_register_reg[HCR_TX_IRQ_EN] & ~receive_full_flag_next;
      dsp_cmd_irq <= dsp_control_register_reg[HCR_CMD_IRQ_EN] & hc_next;
    end
  end

endmodule

/* File: design/hpsl_pkg.sv */
package hpsl_pkg;

  // ==========================================================================
  // Host-visible register addresses, with the high receive/transmit byte first.
  localparam logic [2:0] HA_ICR = 3'h0;
  localparam logic [2:0] HA_CVR = 3'h1;
  localparam logic [2:0] HA_ISR = 3'h2;
  localparam logic [2:0] HA_IVR = 3'h3;
  localparam logic [2:0] HA_BYTE_HIGH = 3'h5;
  localparam logic [2:0] HA_BYTE_MID = 3'h6;
  localparam logic [2:0] HA_BYTE_LOW = 3'h7;

  // ==========================================================================
  // Host-side field positions.
  localparam int ICR_RECV_REQ_EN = 0;
  localparam int ICR_XMIT_REQ_EN = 1;
  localparam int CVR_CMD_BIT = 7;

  // ==========================================================================
  // DSP-side control field positions.
  localparam int HCR_RX_IRQ_EN = 0;
  localparam int HCR_TX_IRQ_EN = 1;
  localparam int HCR_CMD_IRQ_EN = 2;
  localparam int HCR_FLAG_TWO = 3;
  localparam int HCR_FLAG_THREE = 4;
  localparam int PCR_ADDR8_EN = 1;
  localparam int PCR_ADDR9_EN = 2;
  localparam int PCR_MODE_LO = 1;
  localparam int PCR_MODE_HI = 6;
  localparam int PCR_PORT_EN = 6;
  localparam int PCR_MUX_BUS = 11;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] IVR_RESET = 8'h0f;
  localparam logic [6:0] CVR_VECTOR_RESET = 7'h32;
  localparam logic [23:0] CTRL_RESET = 24'h00_0000;

  // ==========================================================================
  // Controller registers on the AXI4-Lite side.
  localparam logic [4:0] CTL_CMD = 5'h00;
  localparam logic [4:0] CTL_STAT = 5'h04;
  localparam logic [4:0] CTL_IRQ_STAT = 5'h08;
  localparam logic [4:0] CTL_IRQ_CLR = 5'h0c;
  localparam logic [4:0] CTL_IRQ_EN = 5'h10;
  localparam int CMD_ADDR_LO = 8;
  localparam int CMD_READ = 11;
  localparam int CMD_VECTOR = 12;
  localparam int EV_DONE = 0;
  localparam int EV_REQUEST = 1;
  localparam int EV_VECTOR = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: design/hpsl_if.sv */
`timescale 1ns/1ns
interface hpsl_if;
  logic [2:0] ha;
  logic host_read;
  logic host_strobe;
  logic [7:0] hd_host;
  logic hd_host_oe;
  logic [7:0] hd_dev;
  logic hd_dev_oe;
  logic host_acknowledge_in;
  logic host_request_out;
  logic transmit_request_out;
  logic receive_request_out;

  modport device (
    input ha,
    input host_read,
    input host_strobe,
    input hd_host,
    input hd_host_oe,
    input host_acknowledge_in,
    output hd_dev,
    output hd_dev_oe,
    output host_request_out,
    output transmit_request_out,
    output receive_request_out
  );

  modport host (
    output ha,
    output host_read,
    output host_strobe,
    output hd_host,
    output hd_host_oe,
    output host_acknowledge_in,
    input hd_dev,
    input hd_dev_oe,
    input host_request_out,
    input transmit_request_out,
    input receive_request_out
  );
endinterface

/* File: design/hpsl_host.sv */
`timescale 1ns/1ns
module hpsl_host
  import hpsl_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  hpsl_if.host hp,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_WAIT, S_ACK} hpsl_state_e;

  // ==========================================================================
  // AXI4-Lite write path. Address and data are held until both have arrived.
  logic aw_got_reg;
  logic w_got_reg;
  logic [4:0] waddr_reg;
  logic [31:0] wdata_reg;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire do_wr = aw_got_reg & w_got_reg & ~s_axi_bvalid;
  wire aw_got_next = (aw_got_reg | aw_take) & ~do_wr;
  wire w_got_next = (w_got_reg | w_take) & ~do_wr;
  wire bvalid_next = do_wr | (s_axi_bvalid & ~s_axi_bready);
  wire wr_known = (waddr_reg == CTL_CMD) | (waddr_reg == CTL_IRQ_CLR) | (waddr_reg == CTL_IRQ_EN);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      waddr_reg <= 5'h00;
      wdata_reg <= 32'h0000_0000;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      s_axi_awready <= ~aw_got_next & ~bvalid_next;
      s_axi_wready <= ~w_got_next & ~bvalid_next;
      s_axi_bvalid <= bvalid_next;
      if (do_wr) begin
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      if (aw_take) begin
        waddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
      end
    end
  end

  // ==========================================================================
  // Host bus sequencer.
  hpsl_state_e state_reg;
  hpsl_state_e state_next;
  logic [7:0] result_reg;
  logic [2:0] ev_stat_reg;
  logic [2:0] ev_en_reg;
  logic req_seen_reg;
  wire cmd_start = do_wr & (waddr_reg == CTL_CMD) & (state_reg == S_IDLE);
  wire cmd_read = wdata_reg[CMD_READ];
  wire cmd_vector = wdata_reg[CMD_VECTOR];
  wire got_data = hp.hd_dev_oe & ((state_reg == S_WAIT) | (state_reg == S_ACK));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (cmd_start) begin
          state_next = cmd_vector ? S_ACK : S_SETUP;
        end
      end
      S_SETUP: begin
        state_next = S_STROBE;
      end
      S_STROBE: begin
        state_next = hp.host_read ? S_WAIT : S_IDLE;
      end
      S_WAIT, S_ACK: begin
        if (got_data) begin
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= S_IDLE;
      hp.ha <= 3'h0;
      hp.host_read <= 1'b1;
      hp.hd_host <= 8'h00;
      hp.hd_host_oe <= 1'b0;
      hp.host_strobe <= 1'b0;
      hp.host_acknowledge_in <= 1'b0;
      result_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (cmd_start) begin
        hp.ha <= wdata_reg[CMD_ADDR_LO +: 3];
        hp.host_read <= cmd_read;
        hp.hd_host <= wdata_reg[7:0];
      end
      hp.hd_host_oe <= ((state_next == S_SETUP) | (state_next == S_STROBE)) & ~(cmd_start ? cmd_read : hp.host_read);
      hp.host_strobe <= state_next == S_STROBE;
      // Acknowledge is raised only for a vector cycle, never during polling reads.
      hp.host_acknowledge_in <= state_next == S_ACK;
      if (got_data) begin
        result_reg <= hp.hd_dev;
      end
    end
  end

  // ==========================================================================
  // Events and interrupt. A new event wins over a clear in the same cycle.
  wire [2:0] ev_set = {got_data & (state_reg == S_ACK),
                       hp.host_request_out & ~req_seen_reg,
                       state_next == S_IDLE && state_reg != S_IDLE};
  wire [2:0] ev_clr = (do_wr & (waddr_reg == CTL_IRQ_CLR)) ? wdata_reg[2:0] : 3'h0;
  wire [2:0] ev_stat_next = ev_set | (ev_stat_reg & ~ev_clr);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ev_stat_reg <= 3'h0;
      ev_en_reg <= 3'h0;
      req_seen_reg <= 1'b0;
      irq <= 1'b0;
    end else begin
      ev_stat_reg <= ev_stat_next;
      req_seen_reg <= hp.host_request_out;
      if (do_wr & (waddr_reg == CTL_IRQ_EN)) begin
        ev_en_reg <= wdata_reg[2:0];
      end
      irq <= |(ev_stat_next & ((do_wr & (waddr_reg == CTL_IRQ_EN)) ? wdata_reg[2:0] : ev_en_reg));
    end
  end

  // ==========================================================================
  // AXI4-Lite read path.
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire rvalid_next = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire [31:0] stat_word = {20'h0_0000, hp.receive_request_out, hp.transmit_request_out,
                           hp.host_request_out, state_reg != S_IDLE, result_reg};
  wire rd_stat = s_axi_araddr == CTL_STAT;
  wire rd_ist = s_axi_araddr == CTL_IRQ_STAT;
  wire rd_ien = s_axi_araddr == CTL_IRQ_EN;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid <= rvalid_next;
      if (ar_take) begin
        s_axi_rdata <= rd_stat ? stat_word : rd_ist ? {29'h0, ev_stat_reg} : rd_ien ? {29'h0, ev_en_reg} : 32'h0000_0000;
        s_axi_rresp <= (rd_stat | rd_ist | rd_ien) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

endmodule

/* File: testbench/hpsl_chk.sv */
`timescale 1ns/1ns
module hpsl_chk
  import hpsl_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] ha,
  input wire logic host_read,
  input wire logic host_strobe,
  input wire logic hd_host_oe,
  input wire logic hd_dev_oe,
  input wire logic host_acknowledge_in,
  input wire logic host_request_out,
  input wire logic transmit_request_out,
  input wire logic receive_request_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================================
  // Link checks.
  a_reset_quiet: assert property ($rose(resetn) |-> !host_request_out && !hd_dev_oe)
    else $error("request or drive right after reset");
  a_req_merge: assert property (host_request_out == (transmit_request_out || receive_request_out))
    else $error("host request differs from its sources");
  a_tx_clear: assert property (host_strobe && !host_read && ha == HA_BYTE_LOW && transmit_request_out
    |=> !transmit_request_out) else $error("transmit request held after low byte write");
  a_rx_clear: assert property (host_strobe && host_read && ha == HA_BYTE_LOW && receive_request_out
    |=> !receive_request_out) else $error("receive request held after low byte read");
  a_vector_drive: assert property (host_request_out && host_acknowledge_in |=> hd_dev_oe)
    else $error("vector not driven during acknowledge");
  a_read_pulse: assert property (host_strobe && host_read && !host_acknowledge_in
    |=> hd_dev_oe ##1 (!hd_dev_oe || host_acknowledge_in)) else $error("read answer not one cycle");
  a_no_clash: assert property (!(hd_dev_oe && hd_host_oe))
    else $error("both ends drive the data bus");
  a_idle_quiet: assert property (hd_dev_oe && !host_acknowledge_in && !$past(host_acknowledge_in)
    |-> $past(host_strobe) && $past(host_read)) else $error("device drives bus unasked");
  // ==========================================================================
  // Main scenarios.
  c_vector: cover property (host_request_out && host_acknowledge_in);
  c_tx_word: cover property (host_strobe && !host_read && ha == HA_BYTE_LOW);
  c_rx_word: cover property (host_strobe && host_read && ha == HA_BYTE_LOW);
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ns
module tb
  import hpsl_pkg::*;
;
  logic clk = 0;
  logic resetn = 0;
  logic [7:0] dctl = 0;
  logic [23:0] dwd = 0;
  logic [15:0] pin_in = 0;
  logic [4:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, seed = 32'h0001_0191, v, s;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, rx_full, tx_empty, cmd_pend, cmd_irq, a8, a9;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata;
  logic [15:0] pin_out, pin_oe, gpio_read;
  logic [23:0] rx_data;
  logic [6:0] cmd_vec;
  logic [1:0] dirq;
  logic [7:0] q;
  logic [23:0] pcrs [3] = '{24'h00_0806, 24'h00_087a, 24'h00_007e};
  int fails = 0;
  int check_count = 0;
  hpsl_if hp_if ();
  hpsl_device hpsl_device_inst (.clk(clk), .resetn(resetn), .hp(hp_if), .soft_reset(dctl[0]), .dsp_ctrl_we(dctl[7]),
    .dsp_pcr_we(dctl[6]), .dsp_ddr_we(dctl[5]), .dsp_gdr_we(dctl[4]), .dsp_wdata(dwd), .dsp_tx_load(dctl[3]),
    .dsp_tx_data(dwd), .dsp_rx_take(dctl[2]), .dsp_cmd_ack(dctl[1]), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .gpio_read(gpio_read), .dsp_rx_data(rx_data), .dsp_rx_full(rx_full), .dsp_tx_empty(tx_empty),
    .dsp_cmd_pending(cmd_pend), .dsp_cmd_vector(cmd_vec), .dsp_rx_irq(dirq[0]), .dsp_tx_irq(dirq[1]),
    .dsp_cmd_irq(cmd_irq),
    .addr_line8_active(a8), .addr_line9_active(a9));
  hpsl_host hpsl_host_inst (.clk(clk), .resetn(resetn), .hp(hp_if), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
  hpsl_chk hpsl_chk_inst (.clk(clk), .resetn(resetn), .ha(hp_if.ha), .host_read(hp_if.host_read),
    .host_strobe(hp_if.host_strobe), .hd_host_oe(hp_if.hd_host_oe), .hd_dev_oe(hp_if.hd_dev_oe),
    .host_acknowledge_in(hp_if.host_acknowledge_in), .host_request_out(hp_if.host_request_out),
    .transmit_request_out(hp_if.transmit_request_out), .receive_request_out(hp_if.receive_request_out));
  initial begin
    forever #4 clk = ~clk;
  end
  // ==========================================================================
  // Helpers.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Both request enables are kept on whenever the status register is checked.
  function automatic logic [7:0] isr_exp(input logic rxf, txe, transmit_ready_flag, f);
    return {rxf | txe, 2'b00, f, f, transmit_ready_flag, txe, rxf};
  endfunction
  function automatic logic en_exp(input logic [23:0] p, input int b);
    return p[PCR_PORT_EN] && (!p[PCR_MUX_BUS] || p[b]);
  endfunction
  task automatic close_out();
    if (fails == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 200) begin
      chk("wait", 1, 0);
      close_out();
    end
  endtask
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid && n < 200);
    rs = bresp;
    tmo(n);
  endtask
  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 0;
    end while (!rvalid && n < 200);
    d = rdata;
    rs = rresp;
    tmo(n);
  endtask
  // One host register cycle through the controller; waits until it is no longer busy.
  task automatic hop(input logic [2:0] a, input logic rd, vec, input logic [7:0] d, output logic [7:0] qo);
    logic [1:0] rs;
    logic [31:0] st;
    int n;
    axi_wr(CTL_CMD, {19'h0, vec, rd, a, d}, rs);
    n = 0;
    do begin
      axi_rd(CTL_STAT, st, rs);
      n++;
    end while (st[8] && n < 200);
    tmo(n);
    qo = st[7:0];
    repeat (3) @(posedge clk);
  endtask
  task automatic xfer(input logic rd, input logic [23:0] w);
    logic [7:0] qo;
    for (int j = 0; j < 3; j++) begin
      hop(3'(HA_BYTE_HIGH + j), rd, 1'b0, w[23-8*j -: 8], qo);
      if (rd) chk("rx_byte", w[23-8*j -: 8], qo);
    end
  endtask
  // Bit order of dctl: control, port control, direction, data, load, take, ack, soft reset.
  task automatic dsp_do(input int k, input logic [23:0] d);
    dwd <= d;
    dctl <= 8'h80 >> k;
    @(posedge clk);
    dctl <= 0;
    repeat (3) @(posedge clk);
  endtask
  // ==========================================================================
  // Scenarios.
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    chk("pin_oe", 0, pin_oe);
    chk("tx_empty", 1, tx_empty);
    v = rnd();
    pin_in <= ~v[31:16];
    dsp_do(2, {8'h00, v[15:0]});
    dsp_do(3, {8'h00, v[31:16]});
    chk("pin_oe", v[15:0], pin_oe);
    chk("pin_out", v[31:16] & v[15:0], pin_out & v[15:0]);
    chk("gpio_read", {16'h0000, ~(v[31:16] ^ v[15:0])}, gpio_read);
    dsp_do(7, 0);
    chk("pin_oe", 0, pin_oe);
    for (int i = 0; i < 3; i++) begin
      dsp_do(1, pcrs[i]);
      chk("addr8", en_exp(pcrs[i], PCR_ADDR8_EN), a8);
      chk("addr9", en_exp(pcrs[i], PCR_ADDR9_EN), a9);
    end
    hop(HA_ICR, 0, 0, 8'h03, q);
    chk("transmit_request_enable", 1, hp_if.transmit_request_out);
    hop(HA_ISR, 1, 0, 0, q);
    chk("isr", isr_exp(0, 1, 1, 0), q);
    v = rnd();
    xfer(0, v[23:0]);
    chk("rx_full", 1, rx_full);
    chk("rx_data", v[23:0], rx_data);
    s = rnd();
    xfer(0, s[23:0]);
    hop(HA_ISR, 1, 0, 0, q);
    chk("isr", isr_exp(0, 0, 0, 0), q);
    chk("transmit_request_enable", 0, hp_if.transmit_request_out);
    dsp_do(5, 0);
    chk("rx_data", s[23:0], rx_data);
    hop(HA_ISR, 1, 0, 0, q);
    chk("isr", isr_exp(0, 1, 0, 0), q);
    dsp_do(5, 0);
    chk("rx_full", 0, rx_full);
    dsp_do(0, 24'h00_001f);
    v = rnd();
    dsp_do(4, v[23:0]);
    chk("receive_request_enable", 1, hp_if.receive_request_out);
    chk("dsp_irq", 0, {tx_empty, dirq});
    hop(HA_ISR, 1, 0, 0, q);
    chk("isr", isr_exp(1, 1, 1, 1), q);
    hop(HA_IVR, 0, 0, v[31:24], q);
    hop(HA_ICR, 0, 1, 0, q);
    chk("vector", v[31:24], q);
    xfer(1, v[23:0]);
    chk("receive_request_enable", 0, hp_if.receive_request_out);
    chk("dsp_irq", 3'h6, {tx_empty, dirq});
    s = rnd();
    dsp_do(4, s[23:0]);
    hop(HA_ICR, 0, 0, 8'h02, q);
    chk("receive_request_enable", 0, hp_if.receive_request_out);
    hop(HA_CVR, 0, 0, {1'b1, v[6:0]}, q);
    chk("cmd_pend", 1, cmd_pend);
    chk("cmd_vec", v[6:0], cmd_vec);
    chk("cmd_irq", 1, cmd_irq);
    dsp_do(6, 0);
    hop(HA_CVR, 1, 0, 0, q);
    chk("cvr", {1'b0, v[6:0]}, q);
    axi_wr(CTL_IRQ_EN, 0, r);
    axi_wr(CTL_IRQ_CLR, 32'h0000_0007, r);
    hop(HA_ISR, 1, 0, 0, q);
    chk("irq", 0, irq);
    axi_rd(CTL_IRQ_STAT, s, r);
    chk("irq_stat", 1, s);
    axi_wr(CTL_IRQ_EN, 32'h0000_0001, r);
    repeat (2) @(posedge clk);
    chk("irq", 1, irq);
    axi_wr(CTL_IRQ_CLR, 32'h0000_0001, r);
    repeat (2) @(posedge clk);
    chk("irq", 0, irq);
    axi_rd(5'h14, s, r);
    chk("rresp", RESP_SLVERR, r);
    axi_wr(5'h14, 0, r);
    chk("bresp", RESP_SLVERR, r);
    close_out();
  end
endmodule
